// File: rtl/txcp_pkg.sv
// txcp_pkg: constants for the transmit buffer command parser
// assumes: 32-bit fifo words, apb register access at 25 MHz
package txcp_pkg;
	// command a fields
	localparam int A_OFS_LSB = 16;
	localparam int A_FIRST_BIT = 13;
	localparam int A_LAST_BIT = 12;
	localparam int SIZE_MSB = 10;
	// command b fields, command a used-bit mask
	localparam int B_CSUM_BIT = 14;
	localparam logic [31:0] B_CMP_MASK = 32'hffffbfff;
	localparam logic [31:0] A_USED_MASK = 32'h00033fff;
	// register offsets
	localparam logic [11:0] REG_STATUS = 12'h000;
	localparam logic [11:0] REG_MASK = 12'h004;
	localparam logic [11:0] REG_CTRL = 12'h008;
	localparam logic [11:0] REG_LAST_A = 12'h00c;
	localparam logic [11:0] REG_LAST_B = 12'h010;
	localparam logic [11:0] REG_COUNT = 12'h014;
	// status bits
	localparam int ST_TXE = 0;
	localparam int ST_BMIS = 1;
	localparam int ST_LEN = 2;
	localparam int ST_SUM = 3;
	localparam int ST_DONE = 4;
	localparam int ST_W = 5;
	localparam logic [ST_W-1:0] MASK_RST = 5'h00;
	localparam logic [31:0] RDZERO = 32'h00000000;
	typedef enum logic [1:0] {
		TXCP_CMDA,
		TXCP_CMDB,
		TXCP_DATA
	} txcp_state_t;
endpackage : txcp_pkg

// File: rtl/txcp_lane.sv
// txcp_lane: byte enables for one payload word
// assumes: caller supplies start lane and bytes still owed by the buffer
`timescale 1ns/1ps
`default_nettype none
module txcp_lane (
	// word position
	input wire logic first_word_i,
	input wire logic [1:0] offset_i,
	// bytes remaining in buffer payload
	input wire logic [10:0] remain_i,
	// result
	output logic [3:0] be_o,
	output logic [2:0] nbytes_o
);
	logic [2:0] avail;
	logic [1:0] start;
	always_comb begin
		start = first_word_i ? offset_i : 2'h0;
		avail = 3'h4 - {1'b0, start};
		// filler past the payload end is never enabled
		nbytes_o = (remain_i < {8'h00, avail}) ? remain_i[2:0] : avail;
		be_o = 4'h0;
		for (int i = 0; i < 4; i++) begin
			if ((3'(i) >= {1'b0, start}) && (3'(i) < ({1'b0, start} + nbytes_o))) begin
				be_o[i] = 1'b1;
			end
		end
	end
endmodule : txcp_lane
`default_nettype wire

// File: rtl/txcp_parser.sv
// txcp_parser: parses two-word commands heading each tx buffer, checks lengths
// assumes: fifo word stream with valid/ready, mac sink with valid/ready, apb slave
`timescale 1ns/1ps
`default_nettype none
module txcp_parser #(
	parameter int LEN_W = 11
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// fifo read side
	input wire logic [31:0] fifo_data_i,
	input wire logic fifo_valid_i,
	output logic fifo_ready_o,
	// mac transmit interface
	output logic [31:0] mac_data_o,
	output logic [3:0] mac_be_o,
	output logic mac_valid_o,
	output logic mac_first_o,
	output logic mac_last_o,
	output logic mac_csum_o,
	input wire logic mac_ready_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// events
	output logic transmitter_error_flag_o,
	output logic irq_o
);
	localparam int ST_W_L = txcp_pkg::ST_W;
	txcp_pkg::txcp_state_t state;
	logic [31:0] cmd_a;
	logic [31:0] cmd_b;
	logic [31:0] frame_b;
	logic in_frame;
	logic [LEN_W-1:0] remain;
	logic [LEN_W-1:0] byte_cnt;
	logic [LEN_W-1:0] size_sum;
	logic first_word;
	logic [ST_W_L-1:0] status;
	logic [ST_W_L-1:0] irq_mask;
	logic csum_engine_en;
	logic out_full;
	logic [3:0] lane_be;
	logic [2:0] lane_n;
	logic take;
	logic data_take;
	logic close_now;
	logic b_mismatch;
	logic len_bad;
	logic sum_bad;
	logic [LEN_W-1:0] next_cnt;
	logic [LEN_W-1:0] next_sum;
	logic [ST_W_L-1:0] ev;
	logic apb_wr;

	function automatic logic [LEN_W-1:0] fld_len(input logic [31:0] w);
		fld_len = LEN_W'(w[txcp_pkg::SIZE_MSB:0]);
	endfunction : fld_len

	// decoded fields of the current command a
	logic [1:0] a_ofs;
	logic a_first;
	logic a_last;
	assign a_ofs = cmd_a[txcp_pkg::A_OFS_LSB +: 2];
	assign a_first = cmd_a[txcp_pkg::A_FIRST_BIT];
	assign a_last = cmd_a[txcp_pkg::A_LAST_BIT];

	txcp_lane u_lane (
		.first_word_i(first_word),
		.offset_i(a_ofs),
		.remain_i(11'(remain)),
		.be_o(lane_be),
		.nbytes_o(lane_n)
	);

	// one output stage; stalls the fifo only in TXCP_DATA while the mac holds off
	assign fifo_ready_o = (state != txcp_pkg::TXCP_DATA) || !out_full || mac_ready_i;
	assign take = fifo_valid_i && fifo_ready_o;
	assign data_take = take && (state == txcp_pkg::TXCP_DATA);
	assign close_now = data_take && (remain <= LEN_W'(lane_n)) && a_last;
	assign next_cnt = byte_cnt + LEN_W'(lane_n);
	// compare masked command b against the one held for the frame
	assign b_mismatch = in_frame && !(cmd_a[txcp_pkg::A_FIRST_BIT]) &&
		((fifo_data_i & txcp_pkg::B_CMP_MASK) != (frame_b & txcp_pkg::B_CMP_MASK));
	assign len_bad = close_now && (next_cnt != fld_len(frame_b));
	assign sum_bad = close_now && (size_sum != fld_len(frame_b));

	// command word walk: a, b, then payload from the third word
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= txcp_pkg::TXCP_CMDA;
		end else if (take) begin
			case (state)
				txcp_pkg::TXCP_CMDA: state <= txcp_pkg::TXCP_CMDB;
				txcp_pkg::TXCP_CMDB: begin
					// zero-size buffer carries no payload words
					state <= (fld_len(cmd_a) == '0) ? txcp_pkg::TXCP_CMDA : txcp_pkg::TXCP_DATA;
				end
				txcp_pkg::TXCP_DATA: begin
					if (remain <= LEN_W'(lane_n)) begin
						state <= txcp_pkg::TXCP_CMDA;
					end
				end
				default: state <= txcp_pkg::TXCP_CMDA;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_a <= txcp_pkg::RDZERO;
			cmd_b <= txcp_pkg::RDZERO;
		end else if (take && state == txcp_pkg::TXCP_CMDA) begin
			cmd_a <= fifo_data_i & txcp_pkg::A_USED_MASK;
		end else if (take && state == txcp_pkg::TXCP_CMDB) begin
			cmd_b <= fifo_data_i;
		end
	end

	// payload bytes still owed by the current buffer
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			remain <= '0;
			first_word <= 1'b0;
		end else if (take && state == txcp_pkg::TXCP_CMDB) begin
			remain <= fld_len(cmd_a);
			first_word <= 1'b1;
		end else if (data_take) begin
			remain <= (remain <= LEN_W'(lane_n)) ? '0 : remain - LEN_W'(lane_n);
			first_word <= 1'b0;
		end
	end

	// frame accumulation: size sum, byte count, reference command b
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			in_frame <= 1'b0;
			frame_b <= txcp_pkg::RDZERO;
			size_sum <= '0;
			byte_cnt <= '0;
		end else if (take && state == txcp_pkg::TXCP_CMDB) begin
			if (a_first) begin
				in_frame <= 1'b1;
				frame_b <= fifo_data_i;
				size_sum <= fld_len(cmd_a);
				byte_cnt <= '0;
			end else begin
				size_sum <= size_sum + fld_len(cmd_a);
			end
		end else if (data_take) begin
			byte_cnt <= next_cnt;
			if (close_now) begin
				in_frame <= 1'b0;
			end
		end else if (take && state == txcp_pkg::TXCP_CMDA && fifo_data_i[txcp_pkg::A_LAST_BIT]
			&& fld_len(fifo_data_i) == '0) begin
			in_frame <= in_frame;
		end
	end

	// output stage toward the mac
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_full <= 1'b0;
			mac_data_o <= txcp_pkg::RDZERO;
			mac_be_o <= 4'h0;
			mac_first_o <= 1'b0;
			mac_last_o <= 1'b0;
			mac_csum_o <= 1'b0;
		end else if (data_take) begin
			out_full <= 1'b1;
			mac_data_o <= fifo_data_i;
			mac_be_o <= lane_be;
			// first payload word of the frame, even when the first buffer is empty
			mac_first_o <= (byte_cnt == '0);
			mac_last_o <= close_now;
			// request held from the first buffer's command b
			mac_csum_o <= (byte_cnt == '0) && csum_engine_en
				&& frame_b[txcp_pkg::B_CSUM_BIT];
		end else if (mac_ready_i) begin
			out_full <= 1'b0;
		end
	end
	assign mac_valid_o = out_full;

	// events, sticky status, mask
	always_comb begin
		ev = '0;
		ev[txcp_pkg::ST_BMIS] = take && state == txcp_pkg::TXCP_CMDB && b_mismatch;
		ev[txcp_pkg::ST_LEN] = len_bad;
		ev[txcp_pkg::ST_SUM] = sum_bad;
		ev[txcp_pkg::ST_TXE] = ev[txcp_pkg::ST_BMIS] | len_bad | sum_bad;
		ev[txcp_pkg::ST_DONE] = close_now;
	end

	assign apb_wr = psel_i && penable_i && pwrite_i;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status <= '0;
		end else begin
			// set wins over a same-cycle clear
			if (apb_wr && paddr_i == txcp_pkg::REG_STATUS) begin
				status <= (status & ~pwdata_i[ST_W_L-1:0]) | ev;
			end else begin
				status <= status | ev;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_mask <= txcp_pkg::MASK_RST;
			csum_engine_en <= 1'b0;
		end else if (apb_wr && paddr_i == txcp_pkg::REG_MASK) begin
			irq_mask <= pwdata_i[ST_W_L-1:0];
		end else if (apb_wr && paddr_i == txcp_pkg::REG_CTRL) begin
			csum_engine_en <= pwdata_i[0];
		end
	end

	assign transmitter_error_flag_o = status[txcp_pkg::ST_TXE];
	assign irq_o = |(status & irq_mask);

	// zero-wait apb; unmapped reads return zero with an error
	assign pready_o = 1'b1;
	always_comb begin
		prdata_o = txcp_pkg::RDZERO;
		pslverr_o = 1'b0;
		case (paddr_i)
			txcp_pkg::REG_STATUS: prdata_o = {27'h0000000, status};
			txcp_pkg::REG_MASK: prdata_o = {27'h0000000, irq_mask};
			txcp_pkg::REG_CTRL: prdata_o = {31'h00000000, csum_engine_en};
			txcp_pkg::REG_LAST_A: prdata_o = cmd_a;
			txcp_pkg::REG_LAST_B: prdata_o = cmd_b;
			txcp_pkg::REG_COUNT: prdata_o = {5'h00, 5'(0), size_sum, byte_cnt};
			default: pslverr_o = psel_i && penable_i;
		endcase
	end
endmodule : txcp_parser
`default_nettype wire

// File: verification/txcp_parser_props.sv
// txcp_parser_props: port checks of the command parser
// assumes: bound to txcp_parser, one clock domain
`timescale 1ns/1ps
`default_nettype none
module txcp_parser_props (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// watched ports
	input wire logic fifo_valid_i,
	input wire logic fifo_ready_o,
	input wire logic [31:0] mac_data_o,
	input wire logic [3:0] mac_be_o,
	input wire logic mac_valid_o,
	input wire logic mac_last_o,
	input wire logic mac_ready_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic transmitter_error_flag_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	wire logic take = fifo_valid_i & fifo_ready_o;
	wire logic clr = psel_i & penable_i & pwrite_i & pwdata_i[0] & (paddr_i == 12'h000);
	property p_after_take;
		$rose(mac_valid_o) |-> $past(take);
	endproperty
	a_after_take: assert property (p_after_take) else $error("word out without take");
	property p_hold;
		mac_valid_o && !mac_ready_i |=> mac_valid_o && $stable(mac_data_o) && $stable(mac_be_o);
	endproperty
	a_hold: assert property (p_hold) else $error("mac word not held");
	property p_refuse;
		!fifo_ready_o |-> mac_valid_o && !mac_ready_i;
	endproperty
	a_refuse: assert property (p_refuse) else $error("fifo refused without stall");
	property p_be;
		mac_valid_o |-> mac_be_o inside {4'h1, 4'h3, 4'h7, 4'hf, 4'he, 4'hc, 4'h8, 4'h6, 4'h2, 4'h4};
	endproperty
	a_be: assert property (p_be) else $error("byte enables not contiguous");
	property p_gap;
		mac_valid_o && mac_last_o && mac_ready_i |=> !mac_valid_o;
	endproperty
	a_gap: assert property (p_gap) else $error("payload before next command");
	property p_ready;
		psel_i |-> pready_o;
	endproperty
	a_ready: assert property (p_ready) else $error("apb wait state");
	property p_err_hold;
		$fell(transmitter_error_flag_o) |-> $past(clr);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag lost");
	property p_unmapped;
		psel_i && penable_i && paddr_i > 12'h014 |-> pslverr_o;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
	c_err: cover property ($rose(transmitter_error_flag_o));
	c_stall: cover property (mac_valid_o && !mac_ready_i);
	c_refuse: cover property (!fifo_ready_o);
endmodule : txcp_parser_props
bind txcp_parser txcp_parser_props u_txcp_parser_props (.mclk_i, .rst_b_i, .fifo_valid_i,
	.fifo_ready_o, .mac_data_o, .mac_be_o, .mac_valid_o, .mac_last_o, .mac_ready_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .transmitter_error_flag_o);
`default_nettype wire

// File: verification/txcp_host_model.sv
// txcp_host_model: host side feeding buffer words to the fifo port
// assumes: bench pushes whole buffers; random gaps between words
`timescale 1ns/1ps
`default_nettype none
module txcp_host_model (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// fifo port
	input wire logic fifo_ready_i,
	output logic [31:0] fifo_data_o,
	output logic fifo_valid_o
);
	logic [31:0] q[$];
	task automatic push(input logic [31:0] w);
		q.push_back(w);
	endtask : push
	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fifo_valid_o <= 1'b0;
			fifo_data_o <= 32'h0;
		end else if (!fifo_valid_o || fifo_ready_i) begin
			if (q.size() != 0 && $urandom_range(3) != 0) begin
				fifo_data_o <= q.pop_front();
				fifo_valid_o <= 1'b1;
			end else begin
				// idle data toggles so no stale word looks valid
				fifo_data_o <= ~fifo_data_o;
				fifo_valid_o <= 1'b0;
			end
		end
	end
endmodule : txcp_host_model
`default_nettype wire

// File: verification/txcp_parser_tb_top.sv
// txcp_parser_tb_top: random multi-buffer frames through the parser
// assumes: host model on fifo port, bench sinks mac side and drives apb
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module txcp_parser_tb_top;
	logic mclk_i = 1'b0, rst_b_i = 1'b0, mac_ready_i = 1'b0;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, csum;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0, fdata, prdata_o, mac_data_o, rd;
	logic [3:0] mac_be_o;
	logic fvalid, fifo_ready_o, mac_valid_o, mac_first_o, mac_last_o, mac_csum_o;
	logic pready_o, pslverr_o, transmitter_error_flag, irq_o;
	logic [7:0] exp[$], got[$];
	int n_mismatch = 0, check_count = 0, nf, nl;
	always #20 mclk_i = ~mclk_i;
	txcp_host_model u_txcp_host_model (.mclk_i, .rst_b_i, .fifo_ready_i(fifo_ready_o),
		.fifo_data_o(fdata), .fifo_valid_o(fvalid));
	txcp_parser u_txcp_parser (.mclk_i, .rst_b_i, .fifo_data_i(fdata), .fifo_valid_i(fvalid),
		.fifo_ready_o, .mac_data_o, .mac_be_o, .mac_valid_o, .mac_first_o, .mac_last_o,
		.mac_csum_o, .mac_ready_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .transmitter_error_flag_o(transmitter_error_flag), .irq_o);
	always @(posedge mclk_i) begin
		if (mac_valid_o && mac_ready_i) begin
			for (int i = 0; i < 4; i++) if (mac_be_o[i]) got.push_back(mac_data_o[8*i+:8]);
			if (mac_first_o) begin
				nf++;
				csum = mac_csum_o;
			end
			nl += int'(mac_last_o);
		end
		mac_ready_i <= $urandom_range(2) != 0;
	end
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
		int t;
		t = 0;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			if (++t > 50) begin
				n_mismatch++;
				results();
			end
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		`CHK(pslverr_o, e)
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge mclk_i);
	endtask : apb
	task automatic buf1(input logic f, input logic l, input int s, input logic [31:0] b);
		logic [1:0] o;
		logic [31:0] w;
		o = 2'($urandom_range(3));
		u_txcp_host_model.push(($urandom & ~txcp_pkg::A_USED_MASK) |
			{14'h0, o, 2'h0, f, l, 1'b0, 11'(s)});
		u_txcp_host_model.push(b);
		// an empty buffer carries no payload words at all
		for (int k = 0; k < ((s == 0) ? 0 : (o + s + 3) / 4 * 4); k++) begin
			w[8*(k%4)+:8] = 8'($urandom);
			if (k >= o && k < o + s) exp.push_back(w[8*(k%4)+:8]);
			if (k % 4 == 3) u_txcp_host_model.push(w);
		end
	endtask : buf1
	task automatic frame(input int s0, input int s1, input int dl, input logic [31:0] bx);
		logic [31:0] b;
		logic ck, e;
		int t;
		ck = 1'($urandom);
		b = 32'(s0 + s1 + dl);
		e = dl != 0 || (bx & txcp_pkg::B_CMP_MASK) != 0;
		exp.delete();
		got.delete();
		nf = 0;
		nl = 0;
		buf1(1'b1, 1'b0, s0, b | (32'(ck) << txcp_pkg::B_CSUM_BIT));
		buf1(1'b0, 1'b1, s1, b ^ bx);
		t = 0;
		do begin
			@(posedge mclk_i);
			if (++t > 2000) begin
				n_mismatch++;
				results();
			end
		end while (u_txcp_host_model.q.size() != 0 || fvalid !== 1'b0 || mac_valid_o !== 1'b0);
		repeat (2) @(posedge mclk_i);
		`CHK(transmitter_error_flag, e)
		if (!e) begin
			`CHK(got.size(), exp.size())
			foreach (exp[i]) `CHK(got[i], exp[i])
			`CHK(nf + 2 * nl, 3)
			`CHK(csum, ck)
		end
		apb(1'b1, txcp_pkg::REG_MASK, 32'h1, 1'b0);
		`CHK(irq_o, e)
		apb(1'b1, txcp_pkg::REG_STATUS, 32'h1f, 1'b0);
		`CHK(irq_o, 1'b0)
		`CHK(transmitter_error_flag, 1'b0)
	endtask : frame
	initial begin
		void'($urandom(32'h17a2));
		repeat (16) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(posedge mclk_i);
		apb(1'b0, txcp_pkg::REG_MASK, 32'h0, 1'b0);
		`CHK(rd[4:0], txcp_pkg::MASK_RST)
		apb(1'b0, 12'h020, 32'h0, 1'b1);
		`CHK(rd, txcp_pkg::RDZERO)
		apb(1'b1, txcp_pkg::REG_CTRL, 32'h1, 1'b0);
		frame(0, 5, 0, 32'h0);
		frame(3, 1, 0, 32'h4000);
		frame(7, 9, 0, 32'h2000);
		frame(7, 9, 1, 32'h0);
		repeat (20) frame($urandom_range(40), $urandom_range(40, 1), 0, 32'h0);
		results();
	end
endmodule : txcp_parser_tb_top
`default_nettype wire
